// ---- core/solc_sync.v ----
// Two flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level from outside the clk_sys domain.
`default_nettype none

module solc_sync
#(
   parameter WIDTH = 6
)
(
   input  wire             clk_sys,
   input  wire             reset_n,
   input  wire [WIDTH-1:0] async_in,
   input  wire [WIDTH-1:0] reset_value,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;

   // ----------------------------------------------------------------------------
   // Synchroniser stages
   // ----------------------------------------------------------------------------
   // The first stage feeds only the second stage, to contain metastability.
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         meta_reg <= reset_value;
         sync_out <= reset_value;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule // solc_sync

`default_nettype wire

// ---- core/solc_top.v ----
// Serial receiver and output control register for eight low-side drivers.
// Assumes link pins arrive unsynchronised and an Avalon-MM master on clk_sys.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`default_nettype none
`include "solc_defs.vh"

module solc_top
(
   input  wire        clk_sys,
   input  wire        reset_n,
   // Avalon-MM register slave
   input  wire [4:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // Serial link from the controller
   input  wire        select_low_n,
   input  wire        serial_clock,
   input  wire        serial_data,
   // Device pins
   input  wire        first_output_force_on,
   input  wire        power_good_reset_n,
   input  wire        brownout_detect,
   output reg  [7:0]  driver_outputs,
   output reg         undervoltage_flag_n
);

   // ----------------------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------------------
   wire [5:0] pins_sync;
   wire       sel_n_s;
   wire       sclk_s;
   wire       mosi_s;
   wire       force_s;
   wire       pgood_n_s;
   wire       brown_s;

   solc_sync #(.WIDTH(6)) u_sync
   (
      .clk_sys     (clk_sys),
      .reset_n     (reset_n),
      .async_in    ({brownout_detect, power_good_reset_n, first_output_force_on,
                     serial_data, serial_clock, select_low_n}),
      .reset_value (6'h11),
      .sync_out    (pins_sync)
   );

   assign sel_n_s   = pins_sync[0];
   assign sclk_s    = pins_sync[1];
   assign mosi_s    = pins_sync[2];
   assign force_s   = pins_sync[3];
   assign pgood_n_s = pins_sync[4];
   assign brown_s   = pins_sync[5];

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   reg  [7:0]  shift_reg;
   reg  [7:0]  shift_next;
   reg  [3:0]  count_reg;
   reg  [3:0]  count_next;
   reg  [7:0]  ctrl_reg;
   reg  [7:0]  ctrl_next;
   reg         sel_prev_reg;
   reg         sclk_prev_reg;
   reg         cfg_serial_en_reg;
   reg  [15:0] words_reg;
   reg  [15:0] words_next;
   reg  [15:0] errors_reg;
   reg  [15:0] errors_next;
   reg         commit;
   reg         frame_error;

   wire        pg_reset;
   wire        selected;
   wire        sclk_rise;
   wire        sel_fall;
   wire        sel_rise;
   wire        bus_take;
   wire        wr_take;
   wire        idle_clock_high;
   wire        outputs_off;
   wire [7:0]  outs_next;
   reg  [31:0] status_word;
   reg  [31:0] read_mux;
   genvar      gi;

   assign pg_reset        = ~pgood_n_s;
   assign selected        = ~sel_n_s;
   assign sclk_rise       = sclk_s & ~sclk_prev_reg;
   assign sel_fall        = sel_prev_reg & ~sel_n_s;
   assign sel_rise        = ~sel_prev_reg & sel_n_s;
   assign bus_take        = (avs_read | avs_write) & ~avs_waitrequest;
   assign wr_take         = avs_write & ~avs_waitrequest;
   // A clock left high across deselect would fake an edge at the next select.
   assign idle_clock_high = sel_n_s & sclk_s;

   // ----------------------------------------------------------------------------
   // Serial shifter and commit
   // ----------------------------------------------------------------------------
   always @*
   begin
      shift_next  = shift_reg;
      count_next  = count_reg;
      ctrl_next   = ctrl_reg;
      commit      = 1'b0;
      frame_error = 1'b0;
      if (pg_reset)
      begin
         ctrl_next  = `SOLC_CTRL_RESET;
         count_next = 4'h0;
         shift_next = 8'h00;
      end
      else if (sel_fall)
      begin
         count_next = 4'h0;
      end
      else if (selected && cfg_serial_en_reg)
      begin
         if (sclk_rise)
         begin
            shift_next = {shift_reg[6:0], mosi_s};
            if (count_reg != 4'hf)
               count_next = count_reg + 4'h1;
         end
      end
      else if (sel_rise && cfg_serial_en_reg)
      begin
         if (count_reg == `SOLC_BITS_PER_WORD)
         begin
            ctrl_next = shift_reg;
            commit    = 1'b1;
         end
         else
            frame_error = 1'b1;
         count_next = 4'h0;
      end
      if (idle_clock_high && !sclk_prev_reg)
         frame_error = 1'b1;
   end

   // ----------------------------------------------------------------------------
   // Counters, with hardware events winning over a software clear
   // ----------------------------------------------------------------------------
   always @*
   begin
      words_next  = words_reg;
      errors_next = errors_reg;
      if (wr_take && avs_address == `SOLC_OFS_WORDS)
         words_next = 16'h0000;
      if (wr_take && avs_address == `SOLC_OFS_ERRORS)
         errors_next = 16'h0000;
      if (commit)
         words_next = words_next + 16'h0001;
      if (frame_error)
         errors_next = errors_next + 16'h0001;
   end

   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         shift_reg     <= 8'h00;
         count_reg     <= 4'h0;
         ctrl_reg      <= `SOLC_CTRL_RESET;
         sel_prev_reg  <= 1'b1;
         sclk_prev_reg <= 1'b0;
         words_reg     <= 16'h0000;
         errors_reg    <= 16'h0000;
      end
      else
      begin
         shift_reg     <= shift_next;
         count_reg     <= count_next;
         ctrl_reg      <= ctrl_next;
         sel_prev_reg  <= sel_n_s;
         sclk_prev_reg <= sclk_s;
         words_reg     <= words_next;
         errors_reg    <= errors_next;
      end
   end

   // ----------------------------------------------------------------------------
   // Driver output gating
   // ----------------------------------------------------------------------------
   // The register keeps its value through a brown-out, so outputs come back
   // to the last programmed state without any new serial word.
   assign outputs_off = pg_reset | brown_s;

   generate
      for (gi = 0; gi < `SOLC_WORD_BITS; gi = gi + 1)
      begin : g_drv
         if (gi == 0)
         begin : g_first
            // The force pin is gated too, so a brown-out also silences output 1.
            assign outs_next[gi] = ~outputs_off & (ctrl_reg[gi] | force_s);
         end
         else
         begin : g_rest
            assign outs_next[gi] = ~outputs_off & ctrl_reg[gi];
         end
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // Driver output and brown-out flag registers
   // ----------------------------------------------------------------------------
   // Registering after the gate keeps every top-level output on a flip-flop.
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         driver_outputs      <= 8'h00;
         undervoltage_flag_n <= 1'b1;
      end
      else
      begin
         undervoltage_flag_n <= ~brown_s;
         driver_outputs      <= outs_next;
      end
   end

   // ----------------------------------------------------------------------------
   // Read data selection
   // ----------------------------------------------------------------------------
   // Status fields come from the synchronised pin views, so a read never
   // samples a raw pin.
   always @*
   begin
      status_word                                        = 32'h0000_0000;
      status_word[`SOLC_ST_UVFLAG_N]                     = ~brown_s;
      status_word[`SOLC_ST_PG_RESET]                     = pg_reset;
      status_word[`SOLC_ST_SELECTED]                     = selected;
      status_word[`SOLC_ST_FORCE_ON]                     = force_s;
      status_word[`SOLC_ST_COUNT_MSB:`SOLC_ST_COUNT_LSB] = count_reg;
   end

   // Unmapped offsets read as zero; writes to them are dropped below.
   always @*
   begin
      case (avs_address)
         `SOLC_OFS_CONFIG:  read_mux = {31'h0, cfg_serial_en_reg};
         `SOLC_OFS_OUTCTRL: read_mux = {24'h0, ctrl_reg};
         `SOLC_OFS_STATUS:  read_mux = status_word;
         `SOLC_OFS_WORDS:   read_mux = {16'h0, words_reg};
         `SOLC_OFS_ERRORS:  read_mux = {16'h0, errors_reg};
         default:           read_mux = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------------------
   // Every access waits exactly one cycle; read data are loaded together with
   // the fall of waitrequest so they stand at the edge the master samples.
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         avs_waitrequest   <= 1'b1;
         avs_readdata      <= 32'h0000_0000;
         cfg_serial_en_reg <= `SOLC_CFG_RESET;
      end
      else
      begin
         if (bus_take)
            avs_waitrequest <= 1'b1;
         else if (avs_read || avs_write)
            avs_waitrequest <= 1'b0;
         else
            avs_waitrequest <= 1'b1;

         if (avs_read && avs_waitrequest)
         begin
            avs_readdata <= read_mux;
         end

         if (wr_take && avs_address == `SOLC_OFS_CONFIG)
            cfg_serial_en_reg <= avs_writedata[`SOLC_CFG_SERIAL_EN];
      end
   end

endmodule // solc_top

`default_nettype wire

// ---- shared/solc_defs.vh ----
// Constants for the serial output latch driver controller.
// Assumes byte addressing on the register bus, one 32-bit word per register.
`ifndef SOLC_DEFS_VH
`define SOLC_DEFS_VH

// ----------------------------------------------------------------------------
// Word format
// ----------------------------------------------------------------------------
`define SOLC_WORD_BITS      8
`define SOLC_CNT_W          4
`define SOLC_BITS_PER_WORD  4'h8
`define SOLC_CTRL_RESET     8'h00

// ----------------------------------------------------------------------------
// Register map (byte offsets)
// ----------------------------------------------------------------------------
`define SOLC_ADDR_W         5
`define SOLC_OFS_CONFIG     5'h00
`define SOLC_OFS_OUTCTRL    5'h04
`define SOLC_OFS_STATUS     5'h08
`define SOLC_OFS_WORDS      5'h0c
`define SOLC_OFS_ERRORS     5'h10

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SOLC_CFG_SERIAL_EN  0
`define SOLC_CFG_RESET      1'b1
`define SOLC_ST_UVFLAG_N    0
`define SOLC_ST_PG_RESET    1
`define SOLC_ST_SELECTED    2
`define SOLC_ST_FORCE_ON    3
`define SOLC_ST_COUNT_LSB   4
`define SOLC_ST_COUNT_MSB   7

// ----------------------------------------------------------------------------
// Link timing, in ns, and the matching counts of 8 ns system cycles
// ----------------------------------------------------------------------------
`define SOLC_CLK_NS         8
`define SOLC_T1_NS          10
`define SOLC_T2_NS          80
`define SOLC_THL_NS         60
`define SOLC_T5_NS          80
`define SOLC_T8_NS          170
`define SOLC_T1_CYC         ((`SOLC_T1_NS + `SOLC_CLK_NS - 1) / `SOLC_CLK_NS)
`define SOLC_T2_CYC         ((`SOLC_T2_NS + `SOLC_CLK_NS - 1) / `SOLC_CLK_NS)
`define SOLC_THL_CYC        ((`SOLC_THL_NS + `SOLC_CLK_NS - 1) / `SOLC_CLK_NS)
`define SOLC_T5_CYC         ((`SOLC_T5_NS + `SOLC_CLK_NS - 1) / `SOLC_CLK_NS)
`define SOLC_T8_CYC         ((`SOLC_T8_NS + `SOLC_CLK_NS - 1) / `SOLC_CLK_NS)

`endif

// ---- sim/solc_host_model.sv ----
// Behavioural serial controller that drives the link pins of the block.
// Assumes the caller enters each task just after a rising edge of clk_sys.
`default_nettype none
module solc_host_model
(
   input  wire logic clk_sys,
   output var  logic select_low_n,
   output var  logic serial_clock,
   output var  logic serial_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      select_low_n = 1'b1;
      serial_clock = 1'b0;
      serial_data  = 1'b0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Each phase lasts eight cycles, 64 ns, the shortest whole count above 60 ns.
   task automatic pulse(input logic b);
      serial_data <= b;
      wait_cyc(8);
      serial_clock <= 1'b1;
      wait_cyc(8);
      serial_clock <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] w, input logic extra);
      select_low_n <= 1'b0;
      for (int i = 7; i >= 0; i--)
         pulse(w[i]);
      if (extra)
         pulse(w[0]);
      wait_cyc(10);
      select_low_n <= 1'b1;
      serial_data  <= ~serial_data;
      wait_cyc(22);
   endtask
   // A clock pulse while deselected breaks the link rules on purpose.
   task automatic stray(input logic b);
      pulse(b);
      wait_cyc(22);
   endtask
endmodule // solc_host_model
`default_nettype wire

// ---- sim/solc_top_asserts.sv ----
// Port assertions for the serial output latch controller.
// Assumes pins stay steady long enough to pass the two-stage synchronisers.
`default_nettype none
module solc_top_asserts
(
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        select_low_n,
   input wire logic        serial_clock,
   input wire logic        serial_data,
   input wire logic        first_output_force_on,
   input wire logic        power_good_reset_n,
   input wire logic        brownout_detect,
   input wire logic [7:0]  driver_outputs,
   input wire logic        undervoltage_flag_n
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   sequence s_req_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_quiet_frame;
      (!select_low_n && !brownout_detect && power_good_reset_n && !first_output_force_on) [*8];
   endsequence
   sequence s_force_held;
      (first_output_force_on && !brownout_detect && power_good_reset_n) [*5];
   endsequence
   sequence s_outs_idle;
      driver_outputs == 8'h00 && undervoltage_flag_n;
   endsequence
   a_wait_one: assert property (s_req_wait |=> !avs_waitrequest)
      else $error("waitrequest not low one cycle after request");
   a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   a_reset_zero: assert property (disable iff (1'b0) !reset_n |=> s_outs_idle)
      else $error("outputs not cleared by reset");
   a_frame_stable: assert property (s_quiet_frame |-> $stable(driver_outputs))
      else $error("outputs changed inside a frame");
   a_pg_off: assert property (!power_good_reset_n [*5] |-> driver_outputs == 8'h00)
      else $error("outputs on during power-good reset");
   a_bo_off: assert property (brownout_detect [*5] |-> driver_outputs == 8'h00 && !undervoltage_flag_n)
      else $error("outputs or flag wrong during brown-out");
   a_bo_clear: assert property (!brownout_detect [*5] |-> undervoltage_flag_n)
      else $error("flag low without brown-out");
   a_force_on: assert property (s_force_held |-> driver_outputs[0])
      else $error("output 1 not forced on");
endmodule // solc_top_asserts
bind solc_top solc_top_asserts i_chk
(
   .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .select_low_n(select_low_n), .serial_clock(serial_clock),
   .serial_data(serial_data), .first_output_force_on(first_output_force_on),
   .power_good_reset_n(power_good_reset_n), .brownout_detect(brownout_detect),
   .driver_outputs(driver_outputs), .undervoltage_flag_n(undervoltage_flag_n)
);
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench: register bus tasks plus a behavioural link controller.
// Assumes the design answers each bus access after one wait cycle.
`default_nettype none
`include "solc_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic        select_low_n, serial_clock, serial_data;
   logic        force_on, pg_n, bo, uv_flag_n;
   logic [7:0]  outs;
   logic [7:0]  words [4] = '{8'h81, 8'h5a, 8'h00, 8'h3c};
   int          err_total = 0;
   int          num_checks = 0;
   solc_top i_dut
   (
      .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .select_low_n(select_low_n), .serial_clock(serial_clock),
      .serial_data(serial_data), .first_output_force_on(force_on), .power_good_reset_n(pg_n),
      .brownout_detect(bo), .driver_outputs(outs), .undervoltage_flag_n(uv_flag_n)
   );
   solc_host_model i_host
   (
      .clk_sys(clk_sys), .select_low_n(select_low_n), .serial_clock(serial_clock), .serial_data(serial_data)
   );
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      chk32({24'h0, g}, {24'h0, e});
   endtask
   // Each access starts one edge late so back-to-back calls never reassign a strobe in one step.
   task automatic av_write(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read    <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      chk32(avs_readdata, e);
   endtask
   task automatic pins(input logic f, input logic p, input logic b);
      force_on <= f;
      pg_n     <= p;
      bo       <= b;
      repeat (8) @(posedge clk_sys);
   endtask
   initial
   begin
      #50000;
      err_total++;
      tally_and_finish();
   end
   initial
   begin
      {reset_n, avs_read, avs_write, avs_address, avs_writedata, force_on, bo} = '0;
      pg_n = 1'b1;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk8(outs, 8'h00);
      chk8({7'h0, uv_flag_n}, 8'h01);
      rd_chk(`SOLC_OFS_CONFIG, 32'h1);
      rd_chk(`SOLC_OFS_OUTCTRL, 32'h0);
      rd_chk(5'h14, 32'h0);
      rd_chk(`SOLC_OFS_STATUS, 32'h1);
      foreach (words[i])
      begin
         i_host.xfer(words[i], 1'b0);
         chk8(outs, words[i]);
      end
      rd_chk(`SOLC_OFS_OUTCTRL, 32'h3c);
      rd_chk(`SOLC_OFS_WORDS, 32'h4);
      i_host.xfer(8'hf0, 1'b1);
      chk8(outs, 8'h3c);
      rd_chk(`SOLC_OFS_ERRORS, 32'h1);
      i_host.stray(1'b1);
      chk8(outs, 8'h3c);
      rd_chk(`SOLC_OFS_ERRORS, 32'h2);
      av_write(`SOLC_OFS_CONFIG, 32'h0);
      i_host.xfer(8'h55, 1'b0);
      chk8(outs, 8'h3c);
      av_write(`SOLC_OFS_CONFIG, 32'h1);
      av_write(`SOLC_OFS_WORDS, 32'h0);
      rd_chk(`SOLC_OFS_WORDS, 32'h0);
      i_host.xfer(8'h00, 1'b0);
      pins(1'b1, 1'b1, 1'b0);
      chk8(outs, 8'h01);
      rd_chk(`SOLC_OFS_STATUS, 32'h9);
      i_host.xfer(8'h80, 1'b0);
      chk8(outs, 8'h81);
      pins(1'b0, 1'b1, 1'b0);
      chk8(outs, 8'h80);
      pins(1'b0, 1'b1, 1'b1);
      chk8(outs, 8'h00);
      chk8({7'h0, uv_flag_n}, 8'h00);
      rd_chk(`SOLC_OFS_STATUS, 32'h0);
      pins(1'b0, 1'b1, 1'b0);
      chk8(outs, 8'h80);
      chk8({7'h0, uv_flag_n}, 8'h01);
      pins(1'b0, 1'b0, 1'b0);
      chk8(outs, 8'h00);
      pins(1'b0, 1'b1, 1'b0);
      chk8(outs, 8'h00);
      rd_chk(`SOLC_OFS_OUTCTRL, 32'h0);
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
